// File: core/nco_mod_pkg.sv
package nco_mod_pkg;
    // ==========================================================
    // widths
    localparam int ACC_W  = 48;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 4;
    localparam int NBYTES = ACC_W / BYTE_W;

    // ==========================================================
    // register indices
    localparam logic [ADDR_W-1:0] CENTER_BASE  = 4'h0;
    localparam logic [ADDR_W-1:0] OFFSET_BASE  = 4'h6;
    localparam logic [ADDR_W-1:0] PHASE_STATUS = 4'hc;
    localparam logic [ADDR_W-1:0] CONTROL_IDX  = 4'hd;
    localparam int               FEEDBACK_BIT = 5;

    // ==========================================================
    // reset values
    localparam logic [ACC_W-1:0]  CENTER_RST  = 48'h4000_0000_0000;
    localparam logic [ACC_W-1:0]  OFFSET_RST  = 48'h0000_0000_0000;
    localparam logic [BYTE_W-1:0] CONTROL_RST = 8'h20;

    // ==========================================================
    // timing: pin to phase output, in clocks; the first synchroniser
    // flop samples the pin at edge zero, so the chain holds one flop more
    // than the latency; the tail is step, accumulator and phase registers
    localparam int LATENCY  = 14;
    localparam int SYNC_LEN = 2;
    localparam int TAIL_LEN = 3;
    localparam int DLY_LEN  = LATENCY + 1 - SYNC_LEN - TAIL_LEN;

    typedef struct packed {
        logic       offset_en;
        logic [1:0] phase_sel;
    } mod_pins_s;
endpackage

// File: core/nco_modulation_control.sv
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module nco_modulation_control (
    // clock and reset
    input  wire logic                               clk_i,
    input  wire logic                               rst_i,
    // register port
    input  wire logic [nco_mod_pkg::ADDR_W-1:0]     addr_i,
    input  wire logic [nco_mod_pkg::BYTE_W-1:0]     wdata_i,
    input  wire logic                               wr_i,
    input  wire logic                               rd_i,
    output logic      [nco_mod_pkg::BYTE_W-1:0]     rdata_o,
    // modulation pins
    input  wire logic                               offset_freq_enable_pin_i,
    input  wire logic                               phase_select_lsb_i,
    input  wire logic                               phase_select_msb_i,
    // phase to the sine lookup
    output logic      [nco_mod_pkg::ACC_W-1:0]      phase_o
);
    import nco_mod_pkg::*;

    // ==========================================================
    // state
    logic [ACC_W-1:0]  center_reg,  center_next;
    logic [ACC_W-1:0]  offset_reg,  offset_next;
    logic [BYTE_W-1:0] control_reg, control_next;
    logic [BYTE_W-1:0] rdata_reg,   rdata_next;
    mod_pins_s         sync1_reg,   sync1_next;
    mod_pins_s         sync2_reg,   sync2_next;
    mod_pins_s         dly_reg [DLY_LEN];
    mod_pins_s         dly_next [DLY_LEN];
    logic [ACC_W-1:0]  step_reg,    step_next;
    logic              en_step_reg, en_step_next;
    logic [1:0]        ph_a_reg,    ph_a_next;
    logic [1:0]        ph_b_reg,    ph_b_next;
    logic [ACC_W-1:0]  acc_reg,     acc_next;
    logic [ACC_W-1:0]  phase_reg,   phase_next;

    // ==========================================================
    // helpers
    function automatic logic [ACC_W-1:0] put_byte(input logic [ACC_W-1:0] word,
                                                  input logic [ADDR_W-1:0] idx,
                                                  input logic [BYTE_W-1:0] data);
        logic [ACC_W-1:0] res;
        res = word;
        res[idx*BYTE_W +: BYTE_W] = data;
        return res;
    endfunction

    function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
        return (a >= base) && (a < base + ADDR_W'(NBYTES));
    endfunction

    // ==========================================================
    // next values
    always_comb begin
        center_next  = center_reg;
        offset_next  = offset_reg;
        control_next = control_reg;
        rdata_next   = '0;
        // each write strobe changes at most one byte register; unmapped and status addresses change none
        if (wr_i) begin
            if (in_range(addr_i, CENTER_BASE)) begin
                center_next = put_byte(center_reg, addr_i - CENTER_BASE, wdata_i);
            end else if (in_range(addr_i, OFFSET_BASE)) begin
                offset_next = put_byte(offset_reg, addr_i - OFFSET_BASE, wdata_i);
            end else if (addr_i == CONTROL_IDX) begin
                control_next = wdata_i;
            end
        end
        // unmapped addresses read as zero
        if (rd_i) begin
            if (in_range(addr_i, CENTER_BASE)) begin
                rdata_next = center_reg[(addr_i - CENTER_BASE)*BYTE_W +: BYTE_W];
            end else if (in_range(addr_i, OFFSET_BASE)) begin
                rdata_next = offset_reg[(addr_i - OFFSET_BASE)*BYTE_W +: BYTE_W];
            end else if (addr_i == PHASE_STATUS) begin
                rdata_next = phase_reg[ACC_W-1 -: BYTE_W];
            end else if (addr_i == CONTROL_IDX) begin
                rdata_next = control_reg;
            end
        end

        // pins meet two flops before any logic reads them
        sync1_next = mod_pins_s'({offset_freq_enable_pin_i, phase_select_msb_i, phase_select_lsb_i});
        sync2_next = sync1_reg;

        // one delay line for both pin groups keeps them aligned
        dly_next[0] = sync2_reg;
        for (int i = 1; i < DLY_LEN; i++) begin
            dly_next[i] = dly_reg[i-1];
        end

        // a new word every clock, so toggling every other clock is tracked
        en_step_next = dly_reg[DLY_LEN-1].offset_en;
        step_next    = center_reg + (dly_reg[DLY_LEN-1].offset_en ? offset_reg : '0);
        ph_a_next    = dly_reg[DLY_LEN-1].phase_sel;
        ph_b_next    = ph_a_reg;

        // feedback cut while the control bit is low
        if (!control_reg[FEEDBACK_BIT]) begin
            acc_next = '0;
        end else begin
            acc_next = acc_reg + step_reg; // wraps at full width
        end

        // quadrant offset lands on the top two bits; a cleared
        // accumulator leaves only the pin offset, so twin parts align
        phase_next = acc_reg + {ph_b_reg, {(ACC_W-2){1'b0}}};
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            center_reg  <= CENTER_RST;
            offset_reg  <= OFFSET_RST;
            control_reg <= CONTROL_RST;
            rdata_reg   <= '0;
            sync1_reg   <= '0;
            sync2_reg   <= '0;
            for (int i = 0; i < DLY_LEN; i++) begin
                dly_reg[i] <= '0;
            end
            step_reg    <= '0;
            en_step_reg <= 1'b0;
            ph_a_reg    <= '0;
            ph_b_reg    <= '0;
            acc_reg     <= '0;
            phase_reg   <= '0;
        end else begin
            center_reg  <= center_next;
            offset_reg  <= offset_next;
            control_reg <= control_next;
            rdata_reg   <= rdata_next;
            sync1_reg   <= sync1_next;
            sync2_reg   <= sync2_next;
            for (int i = 0; i < DLY_LEN; i++) begin
                dly_reg[i] <= dly_next[i];
            end
            step_reg    <= step_next;
            en_step_reg <= en_step_next;
            ph_a_reg    <= ph_a_next;
            ph_b_reg    <= ph_b_next;
            acc_reg     <= acc_next;
            phase_reg   <= phase_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign phase_o = phase_reg;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [4:0] up_cnt_reg, up_cnt_next;
    // $past reaches twelve clocks back, so checks wait until the pipeline has refilled
    always_comb begin
        up_cnt_next = up_cnt_reg;
        if (up_cnt_reg != 5'h1f) begin
            up_cnt_next = up_cnt_reg + 5'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            up_cnt_reg <= '0;
        end else begin
            up_cnt_reg <= up_cnt_next;
        end
    end
    logic warm;
    assign warm = (up_cnt_reg > 5'h10);

    property p_en_latency;
        warm |-> en_step_reg == $past(sync2_reg.offset_en, 11);
    endproperty
    a_en_latency: assert property (p_en_latency) else $error("offset enable latency wrong");

    property p_equal_depth;
        warm |-> ph_b_reg == $past(sync2_reg.phase_sel, 12) && $past(en_step_reg) == $past(sync2_reg.offset_en, 12);
    endproperty
    a_equal_depth: assert property (p_equal_depth) else $error("pin paths misaligned");

    property p_toggle_kept;
        warm && $changed(sync2_reg.offset_en) |-> ##11 $changed(en_step_reg);
    endproperty
    a_toggle_kept: assert property (p_toggle_kept) else $error("enable toggle lost");

    property p_phase_toggle_kept;
        warm && $changed(sync2_reg.phase_sel) |-> ##12 $changed(ph_b_reg);
    endproperty
    a_phase_toggle_kept: assert property (p_phase_toggle_kept) else $error("phase toggle lost");

    property p_step_select;
        warm |-> step_reg == $past(center_reg) + ($past(en_step_next) ? $past(offset_reg) : '0);
    endproperty
    a_step_select: assert property (p_step_select) else $error("step word wrong");

    property p_offset_zeroed;
        warm && !en_step_reg |-> step_reg == $past(center_reg);
    endproperty
    a_offset_zeroed: assert property (p_offset_zeroed) else $error("offset not forced to zero");

    property p_accumulate;
        $past(control_reg[FEEDBACK_BIT]) |-> acc_reg == $past(acc_reg) + $past(step_reg);
    endproperty
    a_accumulate: assert property (p_accumulate) else $error("accumulator did not step");

    property p_feedback_clear;
        !control_reg[FEEDBACK_BIT] |=> acc_reg == '0;
    endproperty
    a_feedback_clear: assert property (p_feedback_clear) else $error("feedback not zeroed");

    property p_known_restart;
        acc_reg == '0 |=> phase_reg == {$past(ph_b_reg), {(ACC_W-2){1'b0}}};
    endproperty
    a_known_restart: assert property (p_known_restart) else $error("restart phase unknown");

    property p_quadrant;
        phase_reg[ACC_W-1 -: 2] == $past(acc_reg[ACC_W-1 -: 2]) + $past(ph_b_reg);
    endproperty
    a_quadrant: assert property (p_quadrant) else $error("quadrant offset wrong");

    property p_sync_depth;
        sync2_reg == $past(mod_pins_s'({offset_freq_enable_pin_i, phase_select_msb_i, phase_select_lsb_i}), 2);
    endproperty
    a_sync_depth: assert property (p_sync_depth) else $error("synchroniser depth wrong");

    property p_byte_write;
        wr_i && addr_i == CENTER_BASE |=> center_reg[BYTE_W-1:0] == $past(wdata_i);
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("center byte not written");

    c_fsk_toggle: cover property (warm && $rose(en_step_reg) ##2 $fell(en_step_reg));
    c_psk_step:   cover property (warm && $changed(ph_b_reg));
    c_restart:    cover property (!control_reg[FEEDBACK_BIT] ##1 control_reg[FEEDBACK_BIT]);
    c_read:       cover property (rd_i && addr_i == PHASE_STATUS);
endmodule

// File: verification/nco_modulation_control_tb.sv
`timescale 1ns/1ps
module nco_modulation_control_tb;
    import nco_mod_pkg::*;
    localparam logic [ACC_W-1:0] CW = 48'hf000_0000_0001;
    localparam logic [ACC_W-1:0] OW = 48'h0000_1234_5678;
    localparam logic [ACC_W-1:0] CB = {CW[47:8], 8'h10};
    logic              clk_i, rst_i, wr_i, rd_i, en_pin, lsb_pin, msb_pin;
    logic [ADDR_W-1:0] addr_i;
    logic [BYTE_W-1:0] wdata_i, rdata_o, rb;
    logic [ACC_W-1:0]  phase_o, p0;
    logic [1:0]        qs [4];
    mod_pins_s         req;
    int                bad_count, total_checks;

    nco_modulation_control u_nco_modulation_control (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .offset_freq_enable_pin_i(en_pin),
        .phase_select_lsb_i(lsb_pin), .phase_select_msb_i(msb_pin), .phase_o(phase_o));
    nco_pin_host u_nco_pin_host (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .offset_freq_enable_pin_o(en_pin),
        .phase_select_lsb_o(lsb_pin), .phase_select_msb_o(msb_pin));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ==========================================================
    // shared tasks
    task automatic check(input string what, input logic [ACC_W-1:0] seen, input logic [ACC_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        // two idle clocks keep any one register to at most 50 M writes a second
        repeat (2) @(posedge clk_i);
    endtask
    task automatic wr48(input logic [3:0] base, input logic [47:0] v);
        for (int i = 0; i < NBYTES; i++) wr(base + i[3:0], v[8*i+:8]);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check("rdata", {40'h0, rdata_o}, {40'h0, exp});
    endtask
    // step seen as the difference of two neighbouring phases, wrapping
    task automatic dchk(input logic [47:0] exp);
        @(posedge clk_i);
        #1 p0 = phase_o;
        @(posedge clk_i);
        #1 check("step", phase_o - p0, exp);
    endtask
    // latency counted from the edge after the one that first shows the new pin level
    task automatic setp(input logic en, input logic [1:0] q, input logic chk, input logic [1:0] oq);
        int n;
        req <= {en, q};
        tick(1);
        for (n = 0; n < 8 && {en_pin, msb_pin, lsb_pin} !== {en, q}; n++) tick(1);
        if (n == 8) begin
            bad_count++;
            close_out();
        end else if (chk) begin
            tick(14);
            check("quad old", phase_o, {oq, 46'h0});
            tick(1);
            check("quad new", phase_o, {q, 46'h0});
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = '0;
        wdata_i = '0;
        req = '0;
        bad_count = 0;
        total_checks = 0;
        qs = '{2'd1, 2'd3, 2'd0, 2'd2};
        tick(4);
        check("phase in reset", phase_o, '0);
        @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 15; i++) begin
            if (i != 12) rdc(i[3:0], i < 6 ? CENTER_RST[8*i+:8] : i < 12 ? OFFSET_RST[8*(i-6)+:8] :
                i == 13 ? CONTROL_RST : 8'h00);
        end
        tick(1);
        check("rdata idle", {40'h0, rdata_o}, '0);
        wr48(CENTER_BASE, CW);
        wr48(OFFSET_BASE, OW);
        rdc(CENTER_BASE + 4'h5, CW[47:40]);
        tick(20);
        dchk(CW);
        setp(1'b1, 2'd0, 1'b0, 2'd0);
        tick(20);
        dchk(CW + OW);
        // one byte rewritten alone gives the mixed word
        wr(CENTER_BASE, 8'h10);
        tick(20);
        dchk(CB + OW);
        wr(CONTROL_IDX, 8'h00);
        tick(20);
        check("held phase", phase_o, '0);
        for (int i = 0; i < 4; i++) setp(i[0], qs[i], 1'b1, i == 0 ? 2'd0 : qs[i-1]);
        rdc(PHASE_STATUS, 8'h80);
        wr(PHASE_STATUS, 8'hff);
        rdc(PHASE_STATUS, 8'h80);
        rdc(CONTROL_IDX, 8'h00);
        wr(CONTROL_IDX, CONTROL_RST);
        tick(20);
        dchk(CB + OW);
        // fast keying: enable flips every two clocks, so any eight steps hold four of each word
        for (int j = 0; j < 16; j++) begin
            req.offset_en <= ~req.offset_en;
            tick(2);
            if (j == 10) p0 = phase_o;
            if (j == 14) check("fast keying", phase_o - p0, (CB << 3) + (OW << 2));
        end
        // fast phase keying with the accumulator held: every sample two clocks on flips 180 degrees
        wr(CONTROL_IDX, 8'h00);
        tick(4);
        for (int j = 0; j < 16; j++) begin
            req.phase_sel[1] <= ~req.phase_sel[1];
            tick(2);
            if (j > 9) check("fast phase", phase_o ^ p0, {2'b10, 46'h0});
            p0 = phase_o;
        end
        close_out();
    end
endmodule

// File: verification/nco_pin_host.sv
`timescale 1ns/1ps
// ==========================================================
// host pin driver: a new level stands two clocks before the next change
module nco_pin_host (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // requested pin levels
    input  wire nco_mod_pkg::mod_pins_s req_i,
    // modulation pins
    output logic                        offset_freq_enable_pin_o,
    output logic                        phase_select_lsb_o,
    output logic                        phase_select_msb_o
);
    import nco_mod_pkg::*;
    mod_pins_s pins_reg, pins_next;
    logic      held_reg, held_next;
    // a faster request is kept waiting while req_i holds it; one withdrawn before the pins are free is dropped
    always_comb begin
        pins_next = pins_reg;
        held_next = 1'b1;
        if (held_reg && req_i != pins_reg) begin
            pins_next = req_i;
            held_next = 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_reg <= '0;
            held_reg <= 1'b0;
        end else begin
            pins_reg <= pins_next;
            held_reg <= held_next;
        end
    end
    assign offset_freq_enable_pin_o = pins_reg.offset_en;
    assign phase_select_lsb_o       = pins_reg.phase_sel[0];
    assign phase_select_msb_o       = pins_reg.phase_sel[1];
endmodule
